// [logic/lls_regs.svh]
// Register map, field positions, reset values and timing counts of the scan driver
`ifndef LLS_REGS_SVH
`define LLS_REGS_SVH
`define LLS_SFR_SCAN_START 8'haf
`define LLS_SFR_CONTROL 8'hb1
`define LLS_SFR_MODE 8'hb2
`define LLS_SFR_WIDTH 8'hb3
`define LLS_SFR_CONTRAST 8'hb9
`define LLS_SEC_SEG_LOW 8'h1f
`define LLS_SEC_SEG_MID 8'h21
`define LLS_SEC_SEG_HIGH 8'h22
`define LLS_SEC_COM_SEL 8'h23
`define LLS_SEC_SEG_SEL 8'h24
`define LLS_SEC_POWER_DOWN 8'h2d
`define LLS_RST_ZERO 8'h00
`define LLS_RST_POWER_DOWN 8'hff
`define LLS_RAM_BASE 16'h1000
`define LLS_RAM_LAST 16'h101b
`define LLS_CTL_IO_ON 6
`define LLS_CTL_DUTY_HI 5
`define LLS_CTL_DUTY_LO 3
`define LLS_CTL_ENGINE 2
`define LLS_CTL_CYCLE 1
`define LLS_CTL_HIGH_CUR 0
`define LLS_MODE_CK_HI 6
`define LLS_MODE_CK_LO 5
`define LLS_MODE_RSEL 4
`define LLS_MODE_FC_HI 3
`define LLS_MODE_FC_LO 2
`define LLS_MODE_RM_HI 1
`define LLS_MODE_RM_LO 0
`define LLS_CON1_FOUR 5
`define LLS_CON1_VOL_HI 3
`define LLS_CON1_VOL_EN 4
`define LLS_RC1M_MHZ 1
`define LLS_LCD_STEP_US 64
`define LLS_LED_STEP_US 16
`define LLS_LED_EXTRA_US 8
`define LLS_LCD_STEP_TICKS (`LLS_LCD_STEP_US * `LLS_RC1M_MHZ)
`define LLS_LED_STEP_TICKS (`LLS_LED_STEP_US * `LLS_RC1M_MHZ)
`define LLS_LED_EXTRA_TICKS (`LLS_LED_EXTRA_US * `LLS_RC1M_MHZ)
`define LLS_SLOW_COM_TICKS 64
`endif

// [logic/lls_pkg.sv]
// Types shared by the scan driver
package lls_pkg;
    typedef enum logic [2:0] {
        LLS_VSS, LLS_THIRD, LLS_QUARTER, LLS_HALF, LLS_TWO_THIRD, LLS_THREE_QUARTER, LLS_LCD_DRIVE_RAIL
    } lls_level_t;
    typedef enum logic {LLS_IDLE, LLS_SCAN} lls_phase_t;
    typedef struct packed {
        logic wrEn;
        logic [15:0] addr;
        logic [7:0] data;
    } lls_bus_req_t;
    typedef struct packed {
        lls_phase_t phase;
        logic scanOn;
        logic [7:0] ctl, mode, width, con1, segLo, segMid;
        logic [4:0] segHi;
        logic [7:0] comSel, segSel, pdAna;
        logic [27:0][7:0] ram;
        logic [7:0] shCtl, shMode, shWidth, shCon1;
        logic [2:0] com;
        logic [12:0] cnt;
        logic parity, done;
        logic [7:0] sfrRd, secRd, ramRd;
        lls_level_t [7:0] lineLv;
        lls_level_t [15:0] segLv;
        logic [23:0] pod;
        logic [2:0] res;
        logic [7:0] ledCom, ledSeg;
    } lls_st_t;
endpackage

// [logic/lls_scan_driver.sv]
// Shared LCD / LED matrix scan driver with its register file and display RAM
`timescale 1ns/100ps
`include "lls_regs.svh"
// How it works
// - Outside 4x4 mode, set common-select bits make lines commons, clear bits leave I/O.
// - In 4x4 mode lines 0-3 are commons, 4-7 segments, per set bit.
// - With high-current sink enabled, common-select bits pick high-current I/O lines.
// - LED segment-select bits give segment function, only outside 4x4 mode.
// - In LCD mode the common count follows only from duty; segments enabled individually.
// - Display RAM bit 1 lights a segment, 0 darkens it; forwarded to pads.
// - In LCD mode RAM byte base+n holds segment n, bit k for common k, up to segment 27.
// - Duty 000/110/111: quarter duty, third bias, commons 0-3, sixteen segments.
// - Duty 001: eighth duty, quarter bias, commons 0-7, sixteen segments.
// - Duty 010: quarter duty, third bias; lines 4-7 become segments 24-27.
// - Duty 011: fifth duty, third bias; lines 5-7 become segments 25-27.
// - Duty 100/101: sixth duty, lines 6-7 segments 26-27; third/quarter bias.
// - Common level from bias, parity and data per the common table.
// - Segment level from bias, parity and data per the segment table.
// - Drive frame parity; pad carrying LCD data has its I/O driver disabled.
// - Resistor string select is one-hot: 20K, 75K, 300K.
// - With 1 MHz clock LCD common time is programmable in 64 us steps, else fixed.
// - Scan-start bit 0 starts scanning when 1, stops when 0.
// - Control bit 6 is master enable of all scan-driven pads.
// - Control bit 2 picks LCD engine when 0, LED engine when 1.
// - Control bit 1 picks continuous scanning when set, single-frame scanning when clear.
// - Control bit 0 turns pins into high-current GPIO, ignoring scan settings.
// - Clock select 00 slow RC, 01 crystal, 10/11 the 1 MHz RC.
// - 1 MHz LCD common period is (scan width + 1) times 64 us.
module lls_scan_driver #(
    parameter int unsigned SlowComTicks = `LLS_SLOW_COM_TICKS
) (
    input wire logic mclk,
    input wire logic srst,
    input wire lls_pkg::lls_bus_req_t sfrReq,
    output logic [7:0] sfrRdData,
    input wire lls_pkg::lls_bus_req_t secReq,
    output logic [7:0] secRdData,
    input wire lls_pkg::lls_bus_req_t ramReq,
    output logic [7:0] ramRdData,
    input wire logic slowInternalRcTick,
    input wire logic xtalTick,
    input wire logic oneMhzLcdClockTick,
    output lls_pkg::lls_level_t [7:0] lineLevel,
    output lls_pkg::lls_level_t [15:0] segLevel,
    output logic [23:0] padOutputDisable,
    output logic frameParity,
    output logic biasFractionChoice,
    output logic [2:0] resistorStringChoice,
    output logic [7:0] ledLineFunc,
    output logic [7:0] ledSegFunc,
    output logic [7:0] ledLineDrive,
    output logic [7:0] ledSegDrive,
    output logic [7:0] highCurrentIo,
    output logic [7:0] analogBlockPowerDown,
    output logic contrastEnable,
    output logic [3:0] contrastLevel,
    output logic frameDone
);
    generate
        if (SlowComTicks < 1 || SlowComTicks > 8191) begin : g_bad_ticks
            $error("SlowComTicks out of range");
        end
    endgenerate

    lls_pkg::lls_st_t st_r;
    lls_pkg::lls_st_t st_nxt;
    logic [7:0] comLines;
    logic frameEnd;

    function automatic logic [3:0] ncomOf(input logic [2:0] duty);
        case (duty)
            3'h1: ncomOf = 4'h8;
            3'h3: ncomOf = 4'h5;
            3'h4, 3'h5: ncomOf = 4'h6;
            default: ncomOf = 4'h4;
        endcase
    endfunction

    function automatic logic quarterOf(input logic [2:0] duty);
        quarterOf = (duty == 3'h1) || (duty == 3'h5);
    endfunction

    function automatic lls_pkg::lls_level_t padLevel(input logic isCom, input logic q,
                                                     input logic par, input logic d);
        if (d) begin
            padLevel = (isCom ^ par) ? lls_pkg::LLS_LCD_DRIVE_RAIL : lls_pkg::LLS_VSS;
        end else if (isCom) begin
            if (par) padLevel = q ? lls_pkg::LLS_THREE_QUARTER : lls_pkg::LLS_TWO_THIRD;
            else padLevel = q ? lls_pkg::LLS_QUARTER : lls_pkg::LLS_THIRD;
        end else begin
            if (par) padLevel = q ? lls_pkg::LLS_HALF : lls_pkg::LLS_THIRD;
            else padLevel = q ? lls_pkg::LLS_HALF : lls_pkg::LLS_TWO_THIRD;
        end
    endfunction

    always_comb begin
        logic [2:0] duty;
        logic [3:0] ncom;
        logic isLed, four, lcdLive, ledLive, tick, last, shared, d;
        logic [12:0] period;
        logic [4:0] ridx;
        logic [4:0] sidx;
        duty = st_r.shCtl[`LLS_CTL_DUTY_HI:`LLS_CTL_DUTY_LO];
        ncom = ncomOf(duty);
        isLed = st_r.shCtl[`LLS_CTL_ENGINE];
        four = st_r.shCon1[`LLS_CON1_FOUR];
        lcdLive = 1'b0;
        ledLive = 1'b0;
        tick = 1'b0;
        last = 1'b0;
        shared = (duty == 3'h2) || (duty == 3'h3) || (duty == 3'h4) || (duty == 3'h5);
        d = 1'b0;
        period = 13'h0001;
        ridx = 5'h00;
        sidx = 5'h00;
        comLines = 8'h00;
        frameEnd = 1'b0;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        // Pads go quiet when scanning is off, closed or overridden by high-current GPIO
        if (st_r.phase == lls_pkg::LLS_SCAN && st_r.ctl[`LLS_CTL_IO_ON] &&
            !st_r.ctl[`LLS_CTL_HIGH_CUR]) begin
            lcdLive = !isLed;
            ledLive = isLed;
        end
        // Period source: LED always counts 1 MHz, LCD follows the clock select
        if (isLed) begin
            tick = oneMhzLcdClockTick;
            period = 13'((13'(st_r.shWidth) + 13'h0001) * 13'(`LLS_LED_STEP_TICKS)
                     + 13'(`LLS_LED_EXTRA_TICKS));
        end else begin
            case (st_r.shMode[`LLS_MODE_CK_HI:`LLS_MODE_CK_LO])
                2'h0: tick = slowInternalRcTick;
                2'h1: tick = xtalTick;
                default: tick = oneMhzLcdClockTick;
            endcase
            if (st_r.shMode[`LLS_MODE_CK_HI]) begin
                // Top two width bits are reserved in LCD mode
                period = 13'((13'(st_r.shWidth[5:0]) + 13'h0001) *
                         13'(`LLS_LCD_STEP_TICKS));
            end else begin
                period = 13'(SlowComTicks);
            end
        end
        if (isLed) last = four ? (st_r.com == 3'h3) : (st_r.com == 3'h7);
        else last = ({1'b0, st_r.com} == 4'(ncom - 4'h1));
        case (st_r.phase)
            lls_pkg::LLS_IDLE: begin
                if (st_r.scanOn) begin
                    st_nxt.phase = lls_pkg::LLS_SCAN;
                    st_nxt.com = 3'h0;
                    st_nxt.cnt = 13'h0000;
                    st_nxt.shCtl = st_r.ctl;
                    st_nxt.shMode = st_r.mode;
                    st_nxt.shWidth = st_r.width;
                    st_nxt.shCon1 = st_r.con1;
                end
            end
            lls_pkg::LLS_SCAN: begin
                if (!st_r.scanOn) begin
                    st_nxt.phase = lls_pkg::LLS_IDLE;
                end else if (tick) begin
                    if (st_r.cnt >= period - 13'h0001) begin
                        st_nxt.cnt = 13'h0000;
                        // New settings only take hold between common periods
                        st_nxt.shCtl = st_r.ctl;
                        st_nxt.shMode = st_r.mode;
                        st_nxt.shWidth = st_r.width;
                        st_nxt.shCon1 = st_r.con1;
                        if (last) begin
                            frameEnd = 1'b1;
                            st_nxt.com = 3'h0;
                            st_nxt.parity = !st_r.parity;
                            if (!st_r.shCtl[`LLS_CTL_CYCLE]) begin
                                st_nxt.phase = lls_pkg::LLS_IDLE;
                                st_nxt.scanOn = 1'b0;
                                st_nxt.done = 1'b1;
                            end
                        end else begin
                            st_nxt.com = st_r.com + 3'h1;
                        end
                    end else begin
                        st_nxt.cnt = st_r.cnt + 13'h0001;
                    end
                end
            end
            default: st_nxt.phase = lls_pkg::LLS_IDLE;
        endcase
        // LCD pads; commons first, then lines lent to segments 24-27
        for (int i = 0; i < 8; i++) begin
            st_nxt.lineLv[i] = lls_pkg::LLS_VSS;
            st_nxt.pod[i] = 1'b0;
            if (lcdLive && (4'(i) < ncom)) begin
                comLines[i] = 1'b1;
                st_nxt.lineLv[i] = padLevel(1'b1, quarterOf(duty), st_r.parity,
                                            3'(i) == st_r.com);
                st_nxt.pod[i] = 1'b1;
            end else if (lcdLive && shared && i >= 4 && st_r.segHi[i - 4]) begin
                ridx = 5'(20 + i);
                d = st_r.ram[ridx][st_r.com];
                st_nxt.lineLv[i] = padLevel(1'b0, quarterOf(duty), st_r.parity, d);
                st_nxt.pod[i] = 1'b1;
            end
        end
        for (int j = 0; j < 16; j++) begin
            sidx = (j < 8) ? 5'(j) : 5'(j + 8);
            st_nxt.segLv[j] = lls_pkg::LLS_VSS;
            st_nxt.pod[8 + j] = 1'b0;
            if (lcdLive && ((j < 8) ? st_r.segLo[j] : st_r.segMid[j - 8])) begin
                d = st_r.ram[sidx][st_r.com];
                st_nxt.segLv[j] = padLevel(1'b0, quarterOf(duty), st_r.parity, d);
                st_nxt.pod[8 + j] = 1'b1;
            end
        end
        // Charge resistor: fast string during the first slice of each common in auto mode
        case (st_r.shMode[`LLS_MODE_RM_HI:`LLS_MODE_RM_LO])
            2'h0: st_nxt.res = st_r.shMode[`LLS_MODE_RSEL] ? 3'h4 : 3'h2;
            2'h1: st_nxt.res = 3'h1;
            default: st_nxt.res = (st_r.cnt < (period >>
                         (3 + st_r.shMode[`LLS_MODE_FC_HI:`LLS_MODE_FC_LO]))) ? 3'h1 :
                         (st_r.shMode[`LLS_MODE_RSEL] ? 3'h4 : 3'h2);
        endcase
        // LED matrix drive; in 4x4 mode the upper lines carry segment data
        st_nxt.ledCom = 8'h00;
        st_nxt.ledSeg = 8'h00;
        if (ledLive && !four) begin
            st_nxt.ledCom = (8'h01 << st_r.com) & st_r.comSel;
            st_nxt.ledSeg = st_r.ram[st_r.com] & st_r.segSel;
        end else if (ledLive) begin
            st_nxt.ledCom = {st_r.ram[st_r.com][3:0] & st_r.comSel[7:4],
                             4'((4'h1 << st_r.com[1:0]) & st_r.comSel[3:0])};
        end
        // Register writes come last so a software start wins over a hardware halt
        if (sfrReq.wrEn) begin
            case (sfrReq.addr[7:0])
                `LLS_SFR_SCAN_START: st_nxt.scanOn = sfrReq.data[0];
                `LLS_SFR_CONTROL: st_nxt.ctl = sfrReq.data & 8'h7f;
                `LLS_SFR_MODE: st_nxt.mode = sfrReq.data;
                `LLS_SFR_WIDTH: st_nxt.width = sfrReq.data;
                `LLS_SFR_CONTRAST: st_nxt.con1 = sfrReq.data & 8'h7f;
                default: ;
            endcase
        end
        if (secReq.wrEn) begin
            case (secReq.addr[7:0])
                `LLS_SEC_SEG_LOW: st_nxt.segLo = secReq.data;
                `LLS_SEC_SEG_MID: st_nxt.segMid = secReq.data;
                `LLS_SEC_SEG_HIGH: st_nxt.segHi = secReq.data[4:0];
                `LLS_SEC_COM_SEL: st_nxt.comSel = secReq.data;
                `LLS_SEC_SEG_SEL: st_nxt.segSel = secReq.data;
                `LLS_SEC_POWER_DOWN: st_nxt.pdAna = secReq.data;
                default: ;
            endcase
        end
        ridx = 5'(ramReq.addr - `LLS_RAM_BASE);
        if (ramReq.wrEn && ramReq.addr >= `LLS_RAM_BASE && ramReq.addr <= `LLS_RAM_LAST) begin
            st_nxt.ram[ridx] = ramReq.data;
        end
        st_nxt.ramRd = (ramReq.addr >= `LLS_RAM_BASE && ramReq.addr <= `LLS_RAM_LAST) ?
                       st_r.ram[ridx] : 8'h00;
        case (sfrReq.addr[7:0])
            `LLS_SFR_SCAN_START: st_nxt.sfrRd = {7'h00, st_r.scanOn};
            `LLS_SFR_CONTROL: st_nxt.sfrRd = st_r.ctl;
            `LLS_SFR_MODE: st_nxt.sfrRd = st_r.mode;
            `LLS_SFR_WIDTH: st_nxt.sfrRd = st_r.width;
            `LLS_SFR_CONTRAST: st_nxt.sfrRd = st_r.con1;
            default: st_nxt.sfrRd = 8'h00;
        endcase
        case (secReq.addr[7:0])
            `LLS_SEC_SEG_LOW: st_nxt.secRd = st_r.segLo;
            `LLS_SEC_SEG_MID: st_nxt.secRd = st_r.segMid;
            `LLS_SEC_SEG_HIGH: st_nxt.secRd = {3'h0, st_r.segHi};
            `LLS_SEC_COM_SEL: st_nxt.secRd = st_r.comSel;
            `LLS_SEC_SEG_SEL: st_nxt.secRd = st_r.segSel;
            `LLS_SEC_POWER_DOWN: st_nxt.secRd = st_r.pdAna;
            default: st_nxt.secRd = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= '0;
            st_r.phase <= lls_pkg::LLS_IDLE;
            st_r.pdAna <= `LLS_RST_POWER_DOWN;
            st_r.res <= 3'h2;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pin functions track the live registers, so software sees its setting at once
    logic ledOwn;
    assign ledOwn = st_r.ctl[`LLS_CTL_ENGINE] && st_r.ctl[`LLS_CTL_IO_ON] &&
                    !st_r.ctl[`LLS_CTL_HIGH_CUR];
    assign ledLineFunc = ledOwn ? st_r.comSel : 8'h00;
    assign ledSegFunc = (ledOwn && !st_r.con1[`LLS_CON1_FOUR]) ? st_r.segSel : 8'h00;
    assign highCurrentIo = st_r.ctl[`LLS_CTL_HIGH_CUR] ? st_r.comSel : 8'h00;
    assign sfrRdData = st_r.sfrRd;
    assign secRdData = st_r.secRd;
    assign ramRdData = st_r.ramRd;
    assign lineLevel = st_r.lineLv;
    assign segLevel = st_r.segLv;
    assign padOutputDisable = st_r.pod;
    assign frameParity = st_r.parity;
    assign biasFractionChoice = quarterOf(st_r.shCtl[`LLS_CTL_DUTY_HI:`LLS_CTL_DUTY_LO]);
    assign resistorStringChoice = st_r.res;
    assign ledLineDrive = st_r.ledCom;
    assign ledSegDrive = st_r.ledSeg;
    assign analogBlockPowerDown = st_r.pdAna;
    assign contrastEnable = st_r.con1[`LLS_CON1_VOL_EN];
    assign contrastLevel = st_r.con1[`LLS_CON1_VOL_HI:0];
    assign frameDone = st_r.done;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_com_select: assert property (
        (ledOwn && !st_r.con1[`LLS_CON1_FOUR]) |-> ledLineFunc == st_r.comSel &&
        ledSegFunc == st_r.segSel) else $error("common select not applied");
    a_matrix_quad: assert property (
        (ledOwn && st_r.con1[`LLS_CON1_FOUR]) |-> ledSegFunc == 8'h00 &&
        ledLineFunc == st_r.comSel) else $error("4x4 line use wrong");
    a_high_current: assert property (
        st_r.ctl[`LLS_CTL_HIGH_CUR] |-> highCurrentIo == st_r.comSel ##1
        (padOutputDisable == 24'h0 && ledLineDrive == 8'h00)) else $error("high current leak");
    a_com_count: assert property (
        (st_r.phase == lls_pkg::LLS_SCAN && st_r.ctl[`LLS_CTL_IO_ON] &&
        !st_r.ctl[`LLS_CTL_HIGH_CUR] && !st_r.shCtl[`LLS_CTL_ENGINE]) |->
        4'($countones(comLines)) == ncomOf(st_r.shCtl[`LLS_CTL_DUTY_HI:`LLS_CTL_DUTY_LO]))
        else $error("common count not from duty");
    a_com_level: assert property (
        (comLines[0] && st_r.com == 3'h0) |=> padOutputDisable[0] &&
        lineLevel[0] == ($past(st_r.parity) ? lls_pkg::LLS_VSS : lls_pkg::LLS_LCD_DRIVE_RAIL))
        else $error("selected common level wrong");
    a_parity_flip: assert property (
        frameEnd |=> st_r.com == 3'h0 && st_r.parity != $past(st_r.parity))
        else $error("parity not toggled at frame end");
    a_single_frame: assert property (
        (frameEnd && !st_r.shCtl[`LLS_CTL_CYCLE] && !sfrReq.wrEn) |=>
        st_r.phase == lls_pkg::LLS_IDLE && frameDone ##1 !frameDone)
        else $error("single-frame scan did not halt");
    a_scan_stop: assert property (
        (st_r.phase == lls_pkg::LLS_SCAN && !st_r.scanOn) |=> st_r.phase == lls_pkg::LLS_IDLE)
        else $error("scan did not stop");
    a_io_closed: assert property (
        !st_r.ctl[`LLS_CTL_IO_ON] |=> padOutputDisable == 24'h0 && ledLineDrive == 8'h00 &&
        ledSegDrive == 8'h00) else $error("pads open while closed");
    a_engine_led: assert property (
        st_r.shCtl[`LLS_CTL_ENGINE] |=> padOutputDisable == 24'h0)
        else $error("LCD pads active in LED mode");
    a_resistor_hot: assert property (
        $onehot(resistorStringChoice)) else $error("resistor select not one-hot");
endmodule // lls_scan_driver

// [test/lls_glass_model.sv]
// Glass model: tells whether segment pads 0 and 1 see a lit voltage
`timescale 1ns/100ps
module lls_glass_model (
    input wire lls_pkg::lls_level_t [7:0] lineLevel,
    input wire lls_pkg::lls_level_t [15:0] segLevel,
    output logic [1:0] segLit
);
    // A pixel lights only where common and segment sit on opposite rails
    always_comb begin
        segLit = 2'b00;
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 8; k++) begin
                if ((lineLevel[k] == lls_pkg::LLS_LCD_DRIVE_RAIL && segLevel[j] == lls_pkg::LLS_VSS) ||
                    (lineLevel[k] == lls_pkg::LLS_VSS && segLevel[j] == lls_pkg::LLS_LCD_DRIVE_RAIL)) begin
                    segLit[j] = 1'b1;
                end
            end
        end
    end
endmodule // lls_glass_model

// [test/test_lls_scan_driver.sv]
// Register and scan tests of the scan driver
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin failCount++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_lls_scan_driver;
    logic mclk, srst, slowTick, fastTick, frameDone, frameParity, biasFractionChoice;
    logic [1:0] tk, segLit;
    logic [2:0] resChoice;
    logic [7:0] ledLineDrive, ledSegDrive;
    lls_pkg::lls_bus_req_t sfrReq, secReq, ramReq;
    logic [7:0] sfrRdData, secRdData, ramRdData, ledLineFunc, ledSegFunc, highCurrentIo;
    lls_pkg::lls_level_t [7:0] lineLevel;
    lls_pkg::lls_level_t [15:0] segLevel;
    logic [23:0] padOutputDisable;
    int failCount = 0, totalChecks = 0, cycles = 0, n;
    lls_scan_driver #(.SlowComTicks(2)) i_lls_scan_driver (.mclk(mclk), .srst(srst),
        .sfrReq(sfrReq), .sfrRdData(sfrRdData), .secReq(secReq), .secRdData(secRdData),
        .ramReq(ramReq), .ramRdData(ramRdData), .slowInternalRcTick(slowTick),
        .xtalTick(slowTick), .oneMhzLcdClockTick(fastTick), .lineLevel(lineLevel),
        .segLevel(segLevel), .padOutputDisable(padOutputDisable), .frameParity(frameParity),
        .biasFractionChoice(biasFractionChoice), .resistorStringChoice(resChoice),
        .ledLineFunc(ledLineFunc), .ledSegFunc(ledSegFunc), .ledLineDrive(ledLineDrive),
        .ledSegDrive(ledSegDrive), .highCurrentIo(highCurrentIo),
        .analogBlockPowerDown(), .contrastEnable(), .contrastLevel(), .frameDone(frameDone));
    lls_glass_model i_lls_glass_model (.lineLevel(lineLevel), .segLevel(segLevel),
        .segLit(segLit));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Slow and crystal ticks pulse every fourth cycle, the fast source every second,
    // so a wrong clock select shows up as a wrong common period
    always @(posedge mclk) begin
        tk <= tk + 2'h1;
        slowTick <= (tk == 2'h0);
        fastTick <= !tk[0];
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            report_and_stop();
        end
    end
    task automatic wr(input int p, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        if (p == 0) sfrReq <= '{1'b1, a, d};
        else if (p == 1) secReq <= '{1'b1, a, d};
        else ramReq <= '{1'b1, a, d};
        @(posedge mclk);
        sfrReq.wrEn <= 1'b0;
        secReq.wrEn <= 1'b0;
        ramReq.wrEn <= 1'b0;
    endtask
    task automatic rd(input int p, input logic [15:0] a, input logic [7:0] ex);
        @(posedge mclk);
        if (p == 0) sfrReq <= '{1'b0, a, 8'h00};
        else if (p == 1) secReq <= '{1'b0, a, 8'h00};
        else ramReq <= '{1'b0, a, 8'h00};
        @(posedge mclk);
        #1;
        `CHK("read data", ex, (p == 0) ? sfrRdData : (p == 1) ? secRdData : ramRdData)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A selected common sits on a rail while its pad carries LCD data
    function automatic logic onRail(input int k);
        return padOutputDisable[k] && (lineLevel[k] inside {lls_pkg::LLS_LCD_DRIVE_RAIL, lls_pkg::LLS_VSS});
    endfunction
    // Bounded wait for a pad condition, sampled after the edge has settled
    `define WAITFOR(c) for (n = 0; n < 400 && !(c); n++) begin @(posedge mclk); #1; end \
        `CHK("wait", 1'b1, 1'((c)))
    initial begin
        {tk, slowTick, fastTick} = '0;
        sfrReq = '0;
        secReq = '0;
        ramReq = '0;
        srst = 1'b1;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rd(0, 16'h00af, 8'h00); rd(0, 16'h00b1, 8'h00); rd(0, 16'h00b9, 8'h00);
        rd(1, 16'h0023, 8'h00); rd(1, 16'h0024, 8'h00); rd(1, 16'h002d, 8'hff);
        `CHK("resistor reset", 3'h2, resChoice)
        wr(0, 16'h00b9, 8'hff); rd(0, 16'h00b9, 8'h7f);
        wr(1, 16'h0022, 8'hff); rd(1, 16'h0022, 8'h1f);
        wr(0, 16'h0010, 8'hff); rd(0, 16'h0010, 8'h00);
        wr(2, 16'h1000, 8'h01); wr(2, 16'h1001, 8'h02); rd(2, 16'h1001, 8'h02);
        rd(2, 16'h101c, 8'h00);
        $display("test registers done");
        wr(1, 16'h0023, 8'ha5); wr(1, 16'h0024, 8'h3c); wr(0, 16'h00b1, 8'h44);
        wr(0, 16'h00b9, 8'h00); #1;
        `CHK("line func", 8'ha5, ledLineFunc)
        `CHK("seg func", 8'h3c, ledSegFunc)
        wr(0, 16'h00b9, 8'h20); #1;
        `CHK("line func 4x4", 8'ha5, ledLineFunc)
        `CHK("seg func 4x4", 8'h00, ledSegFunc)
        wr(0, 16'h00b9, 8'h00); wr(0, 16'h00b1, 8'h41); #1;
        `CHK("high current", 8'ha5, highCurrentIo)
        $display("test pin functions done");
        wr(1, 16'h001f, 8'hff); wr(0, 16'h00b1, 8'h42); wr(0, 16'h00af, 8'h01);
        `WAITFOR(lineLevel[0] === lls_pkg::LLS_LCD_DRIVE_RAIL && frameParity === 1'b0)
        `CHK("com1 level", lls_pkg::LLS_THIRD, lineLevel[1])
        `CHK("seg0 level", lls_pkg::LLS_VSS, segLevel[0])
        `CHK("seg1 level", lls_pkg::LLS_TWO_THIRD, segLevel[1])
        `CHK("pad disable", 2'b11, {padOutputDisable[8], padOutputDisable[0]})
        `CHK("lit", 2'b01, segLit)
        `WAITFOR(lineLevel[1] === lls_pkg::LLS_LCD_DRIVE_RAIL)
        `CHK("com0 after step", lls_pkg::LLS_THIRD, lineLevel[0])
        `CHK("lit com1", 2'b10, segLit)
        `WAITFOR(lineLevel[0] === lls_pkg::LLS_VSS && frameParity === 1'b1)
        `CHK("com1 even", lls_pkg::LLS_TWO_THIRD, lineLevel[1])
        `CHK("seg0 even", lls_pkg::LLS_LCD_DRIVE_RAIL, segLevel[0])
        `CHK("seg1 even", lls_pkg::LLS_THIRD, segLevel[1])
        `CHK("parity", 1'b1, frameParity)
        `CHK("lit even", 2'b01, segLit)
        wr(0, 16'h00af, 8'h00); repeat (3) @(posedge mclk); #1;
        `CHK("pads off", 24'h000000, padOutputDisable)
        wr(0, 16'h00b1, 8'h4a); wr(0, 16'h00af, 8'h01);
        `WAITFOR(lineLevel[0] === lls_pkg::LLS_LCD_DRIVE_RAIL)
        `CHK("quarter bias", 1'b1, biasFractionChoice)
        `CHK("com1 quarter", lls_pkg::LLS_QUARTER, lineLevel[1])
        wr(0, 16'h00af, 8'h00);
        $display("test lcd scan done");
        wr(0, 16'h00b1, 8'h40); wr(0, 16'h00af, 8'h01);
        `WAITFOR(frameDone === 1'b1)
        `CHK("frame done", 1'b1, frameDone)
        rd(0, 16'h00af, 8'h00);
        $display("test single frame done");
        // Fast clock, width 0x41: reserved top bits dropped, (1+1)*64 ticks of two cycles
        wr(0, 16'h00b2, 8'h41); wr(0, 16'h00b3, 8'h41); wr(0, 16'h00b1, 8'h42);
        wr(0, 16'h00af, 8'h01);
        `WAITFOR(onRail(1))
        `WAITFOR(onRail(2))
        `CHK("fast period", 256, n)
        `CHK("fast resistor", 3'h1, resChoice)
        wr(0, 16'h00af, 8'h00); wr(0, 16'h00b3, 8'h00);
        $display("test fast clock done");
        // LED commons last 24 fast ticks each; common 1 is not selected and drives nothing
        wr(2, 16'h1000, 8'h3f); wr(2, 16'h1002, 8'hf0); wr(0, 16'h00b1, 8'h46);
        wr(0, 16'h00af, 8'h01);
        `WAITFOR(ledLineDrive === 8'h01)
        `CHK("led seg com0", 8'h3c, ledSegDrive)
        `WAITFOR(ledLineDrive === 8'h04)
        `CHK("led seg com2", 8'h30, ledSegDrive)
        wr(0, 16'h00af, 8'h00);
        $display("test led matrix done");
        report_and_stop();
    end
endmodule // test_lls_scan_driver
